// ===== verilog/ep_status_pkg.sv
// constants and types for the endpoint status and buffer command block
package ep_status_pkg;
    localparam int NUM_EP  = 16;
    localparam int EP_W    = 4;
    localparam int WORD_W  = 16;
    // command codes; low nibble selects the endpoint index, except the whole-byte setup ack F4h
    localparam logic [3:0] GRP_STALL    = 4'h4;
    localparam logic [3:0] GRP_STATUS   = 4'h5;
    localparam logic [3:0] GRP_VALIDATE = 4'h6;
    localparam logic [3:0] GRP_CLEAR    = 4'h7;
    localparam logic [3:0] GRP_UNSTALL  = 4'h8;
    localparam logic [3:0] GRP_CHECK    = 4'hD;
    localparam logic [7:0] CMD_ACK_SETUP = 8'hF4;
    // endpoint indices of the two control endpoints
    localparam logic [3:0] EP_CTRL_OUT = 4'h0;
    localparam logic [3:0] EP_CTRL_IN  = 4'h1;
    // status byte bit positions
    localparam int BIT_HALTED   = 7;
    localparam int BIT_FULL2    = 6;
    localparam int BIT_FULL1    = 5;
    localparam int BIT_TOGGLE   = 4;
    localparam int BIT_CLOBBER  = 3;
    localparam int BIT_SETUP    = 2;
    localparam int BIT_CPU_SEL  = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // events from the usb link logic, same clock
    typedef enum logic [2:0] {
        EV_SETUP_TOKEN = 3'b001,  // setup token, data being written
        EV_SETUP_DONE  = 3'b010,  // setup data fully written
        EV_OUT_DONE    = 3'b011,  // good out packet stored
        EV_IN_SENT     = 3'b100,  // in packet acknowledged by host
        EV_DMA_WRAP    = 3'b101,  // dma reached end of primary buffer
        EV_NONE        = 3'b000
    } usb_event_kind_t;

    typedef struct packed {
        logic            valid;
        usb_event_kind_t kind;
        logic [3:0]      ep;
    } usb_event_t;

    typedef struct packed {
        logic halted;
        logic full2;
        logic full1;
        logic toggle;
        logic clobbered;
        logic setup_present;
        logic cpu_sel;
        logic usb_sel;
        logic writing;
    } ep_state_t;

    localparam ep_state_t EP_RESET = '0;
endpackage

// ===== verilog/ep_status_commands.sv
// endpoint status, stall and buffer control command engine
`timescale 1ns/100ps

module ep_status_commands (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      cs_n,
    input  wire logic                      a0,
    input  wire logic                      wr_n,
    input  wire logic                      rd_n,
    input  wire logic [15:0]               data_in,
    output logic      [15:0]               data_out,
    output logic                           data_oe,
    input  wire logic [15:0]               ep_dbl_buf,
    input  wire ep_status_pkg::usb_event_t usb_event,
    output logic      [15:0]               out_accept,
    output logic      [15:0]               in_ready,
    output logic      [15:0]               ep_halted,
    output logic      [15:0]               in_toggle,
    output logic                           irq_clear,
    output logic      [3:0]                irq_clear_ep
);
    // two-stage synchronisers for the bus pins; stage3 only for edges
    logic [19:0] pin_s1;
    logic [19:0] pin_s2;
    logic        wr_s3;
    logic        rd_s3;
    logic        cs_ok;
    logic        wr_done;
    logic        rd_start;
    logic        rd_active;
    logic [7:0]  code;
    logic [3:0]  grp;
    logic [3:0]  idx;

    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic [1:0]  ack_wait;
    logic [1:0]  next_ack_wait;
    logic        last_ctrl;
    logic        next_last_ctrl;
    logic        next_irq_clear;
    logic [3:0]  next_irq_clear_ep;
    logic        data_oe_q;
    logic        next_data_oe;
    logic [15:0] data_out_q;
    logic [15:0] next_data_out;

    logic [15:0] hit_stall;
    logic [15:0] hit_unstall;
    logic [15:0] hit_validate;
    logic [15:0] hit_clear;
    logic [15:0] hit_read;
    logic        setup_lock;

    ep_status_pkg::ep_state_t ep      [ep_status_pkg::NUM_EP];
    ep_status_pkg::ep_state_t next_ep [ep_status_pkg::NUM_EP];

    function automatic logic [7:0] status_byte(
        input ep_status_pkg::ep_state_t s);
        logic [7:0] b;
        b = ep_status_pkg::STATUS_RESET;
        b[ep_status_pkg::BIT_HALTED]  = s.halted;
        b[ep_status_pkg::BIT_FULL2]   = s.full2;
        b[ep_status_pkg::BIT_FULL1]   = s.full1;
        b[ep_status_pkg::BIT_TOGGLE]  = s.toggle;
        b[ep_status_pkg::BIT_CLOBBER] = s.clobbered;
        b[ep_status_pkg::BIT_SETUP]   = s.setup_present;
        b[ep_status_pkg::BIT_CPU_SEL] = s.cpu_sel;
        return b;
    endfunction

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_s1 <= 20'hF0000;
            pin_s2 <= 20'hF0000;
            wr_s3  <= 1'b1;
            rd_s3  <= 1'b1;
        end else begin
            pin_s1 <= {cs_n, a0, wr_n, rd_n, data_in};
            pin_s2 <= pin_s1;
            wr_s3  <= pin_s2[17];
            rd_s3  <= pin_s2[16];
        end
    end

    // writes act on the strobe's rising edge, when data has settled
    assign cs_ok     = !pin_s2[19];
    assign wr_done   = cs_ok && pin_s2[17] && !wr_s3;
    assign rd_start  = cs_ok && !pin_s2[16] && rd_s3 && !pin_s2[18];
    assign rd_active = cs_ok && !pin_s2[16] && !pin_s2[18];
    assign code      = pin_s2[7:0];
    assign grp       = code[7:4];
    assign idx       = code[3:0];
    assign setup_lock = |ack_wait;

    // command decode into per-endpoint pulses
    always_comb begin
        logic cmd;
        cmd          = wr_done && pin_s2[18];
        hit_stall    = 16'h0000;
        hit_unstall  = 16'h0000;
        hit_validate = 16'h0000;
        hit_clear    = 16'h0000;
        hit_read     = 16'h0000;
        if (cmd) begin
            case (grp)
                ep_status_pkg::GRP_STALL:   hit_stall[idx]   = 1'b1;
                ep_status_pkg::GRP_UNSTALL: hit_unstall[idx] = 1'b1;
                ep_status_pkg::GRP_STATUS:  hit_read[idx]    = 1'b1;
                ep_status_pkg::GRP_VALIDATE: begin
                    // 60h would target the out endpoint: ignored
                    if (idx != ep_status_pkg::EP_CTRL_OUT &&
                        !(idx == ep_status_pkg::EP_CTRL_IN && setup_lock))
                        hit_validate[idx] = 1'b1;
                end
                ep_status_pkg::GRP_CLEAR: begin
                    if (idx != ep_status_pkg::EP_CTRL_IN &&
                        !(idx == ep_status_pkg::EP_CTRL_OUT && setup_lock))
                        hit_clear[idx] = 1'b1;
                end
                default: ;
            endcase
        end
    end

    // bus side: result latch, setup lock, interrupt clear
    always_comb begin
        logic cmd;
        cmd               = wr_done && pin_s2[18];
        next_rdata        = rdata;
        next_ack_wait     = ack_wait;
        next_last_ctrl    = last_ctrl;
        next_irq_clear    = 1'b0;
        next_irq_clear_ep = irq_clear_ep;
        next_data_oe      = rd_active;
        next_data_out     = rd_start ? rdata : data_out_q;
        if (cmd) begin
            if (idx[3:1] == 3'b000 && code != ep_status_pkg::CMD_ACK_SETUP)
                next_last_ctrl = idx[0];
            if (grp == ep_status_pkg::GRP_STATUS) begin
                next_rdata        = {8'h00, status_byte(ep[idx])};
                next_irq_clear    = 1'b1;
                next_irq_clear_ep = idx;
            end else if (grp == ep_status_pkg::GRP_CHECK) begin
                next_rdata = {8'h00, status_byte(ep[idx])};
            end else if (code == ep_status_pkg::CMD_ACK_SETUP) begin
                // ack goes to the control endpoint last addressed
                next_ack_wait[last_ctrl] = 1'b0;
            end
        end
        if (usb_event.valid &&
            usb_event.kind == ep_status_pkg::EV_SETUP_TOKEN)
            next_ack_wait = 2'b11;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata        <= 16'h0000;
            ack_wait     <= 2'b00;
            last_ctrl    <= 1'b0;
            irq_clear    <= 1'b0;
            irq_clear_ep <= 4'h0;
            data_oe_q    <= 1'b0;
            data_out_q   <= 16'h0000;
        end else begin
            rdata        <= next_rdata;
            ack_wait     <= next_ack_wait;
            last_ctrl    <= next_last_ctrl;
            irq_clear    <= next_irq_clear;
            irq_clear_ep <= next_irq_clear_ep;
            data_oe_q    <= next_data_oe;
            data_out_q   <= next_data_out;
        end
    end

    assign data_out = data_out_q;
    assign data_oe  = data_oe_q;

    // per-endpoint state; bus commands reach it through the hit_ pulses, the link through usb_event
    genvar i;
    generate
        for (i = 0; i < ep_status_pkg::NUM_EP; i++) begin : g_ep
            logic ev;
            logic is_ctrl;
            logic dbl;
            logic usb_full;
            assign ev       = usb_event.valid &&
                              usb_event.ep == 4'(i);
            assign is_ctrl  = (i < 2);
            assign dbl      = ep_dbl_buf[i] && !is_ctrl;
            assign usb_full = ep[i].usb_sel ? ep[i].full2 : ep[i].full1;

            always_comb begin
                ep_status_pkg::ep_state_t n;
                logic setup_ev;
                logic unstall;
                n        = ep[i];
                setup_ev = usb_event.valid && is_ctrl &&
                           usb_event.kind == ep_status_pkg::EV_SETUP_TOKEN;
                unstall  = ep[i].halted &&
                           (hit_unstall[i] || setup_ev);
                if (hit_stall[i])
                    n.halted = 1'b1;
                if (hit_unstall[i])
                    n.halted = 1'b0;
                if (unstall) begin
                    n.halted  = 1'b0;
                    n.full1   = 1'b0;
                    n.full2   = 1'b0;
                    n.toggle  = 1'b0;
                    n.cpu_sel = 1'b0;
                    n.usb_sel = 1'b0;
                end
                if (hit_validate[i]) begin
                    if (ep[i].cpu_sel) n.full2 = 1'b1;
                    else               n.full1 = 1'b1;
                    if (dbl) n.cpu_sel = !ep[i].cpu_sel;
                end
                if (hit_clear[i]) begin
                    if (ep[i].cpu_sel) n.full2 = 1'b0;
                    else               n.full1 = 1'b0;
                    n.setup_present = 1'b0;
                    if (dbl) n.cpu_sel = !ep[i].cpu_sel;
                end
                // a read clears the setup_clobbered_flag flag only after writing ends
                if (hit_read[i] && !ep[i].writing)
                    n.clobbered = 1'b0;
                if (ev) begin
                    case (usb_event.kind)
                        ep_status_pkg::EV_SETUP_TOKEN: begin
                            if (i == 0) begin
                                // previous setup not yet acked or stalled
                                if (setup_lock && !ep[i].halted)
                                    n.clobbered = 1'b1;
                                n.writing       = 1'b1;
                                n.setup_present = 1'b1;
                                n.full1         = 1'b1;
                            end
                        end
                        ep_status_pkg::EV_SETUP_DONE:
                            n.writing = 1'b0;
                        ep_status_pkg::EV_OUT_DONE: begin
                            // ignored when full: link answered NAK
                            if (!usb_full && !ep[i].halted) begin
                                if (ep[i].usb_sel) n.full2 = 1'b1;
                                else               n.full1 = 1'b1;
                                n.toggle = !ep[i].toggle;
                                if (dbl) n.usb_sel = !ep[i].usb_sel;
                            end
                        end
                        ep_status_pkg::EV_IN_SENT: begin
                            if (usb_full) begin
                                if (ep[i].usb_sel) n.full2 = 1'b0;
                                else               n.full1 = 1'b0;
                                n.toggle = !ep[i].toggle;
                                if (dbl) n.usb_sel = !ep[i].usb_sel;
                            end
                        end
                        ep_status_pkg::EV_DMA_WRAP:
                            if (dbl) n.cpu_sel = 1'b1;
                        default: ;
                    endcase
                end
                next_ep[i] = n;
            end

            always_ff @(posedge clk) begin
                if (!reset_n)
                    ep[i] <= ep_status_pkg::EP_RESET;
                else
                    ep[i] <= next_ep[i];
            end

            // the link must NAK out packets while this is low
            assign out_accept[i] = !usb_full && !ep[i].halted;
            // control out never sends, though setup data fills its buffer
            assign in_ready[i]   = usb_full && !ep[i].halted &&
                                   (i != 0);
            assign ep_halted[i]  = ep[i].halted;
            assign in_toggle[i]  = ep[i].toggle;
        end
    endgenerate
endmodule // ep_status_commands

// ===== sim/ep_status_checker.sv
// assertion checker for the endpoint command block
`timescale 1ns/100ps
module ep_status_checker (
    input wire logic                      clk,
    input wire logic                      reset_n,
    input wire logic                      cs_n,
    input wire logic                      a0,
    input wire logic                      wr_n,
    input wire logic                      rd_n,
    input wire logic [15:0]               data_out,
    input wire logic                      data_oe,
    input wire logic [15:0]               ep_dbl_buf,
    input wire ep_status_pkg::usb_event_t usb_event,
    input wire logic [15:0]               out_accept,
    input wire logic [15:0]               in_ready,
    input wire logic [15:0]               ep_halted,
    input wire logic [15:0]               in_toggle,
    input wire logic                      irq_clear
);
    logic [3:0] wr_age;
    logic [3:0] next_wr_age;
    logic       wr_prev;
    logic       next_wr_prev;
    // cycles since the write strobe rose; saturates so it never wraps
    always_comb begin
        next_wr_prev = wr_n;
        next_wr_age  = (wr_age == 4'hF) ? wr_age : wr_age + 4'h1;
        if (wr_n && !wr_prev) next_wr_age = 4'h0;
    end
    always_ff @(posedge clk) begin
        wr_prev <= reset_n ? next_wr_prev : 1'b1;
        wr_age  <= reset_n ? next_wr_age : 4'hF;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_oe_idle; cs_n [*4] |-> !data_oe; endproperty
    property p_upper_zero; data_oe |-> data_out[15:8] == 8'h00; endproperty
    property p_irq_one; irq_clear |=> !irq_clear; endproperty
    property p_read_lat;
        $fell(rd_n) && !cs_n && !a0 |-> ##[2:4] data_oe;
    endproperty
    property p_out_nak;
        usb_event.valid && usb_event.kind == ep_status_pkg::EV_OUT_DONE
        && !ep_dbl_buf[usb_event.ep] |=> !out_accept[$past(usb_event.ep)];
    endproperty
    property p_setup_unstall;
        usb_event.valid && usb_event.kind == ep_status_pkg::EV_SETUP_TOKEN
        && usb_event.ep[3:1] == 3'h0 |=> ep_halted[1:0] == 2'b00;
    endproperty
    property p_halt_cause;
        !$stable(ep_halted) |-> $past(usb_event.valid)
        || wr_age inside {[4'h1:4'h6]};
    endproperty
    property p_unstall_init;
        |($past(ep_halted) & ~ep_halted) |->
        (($past(ep_halted) & ~ep_halted) & (in_toggle | in_ready)) == '0;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("bus driven idle");
    a_upper_zero: assert property (p_upper_zero) else $error("upper byte");
    a_irq_one: assert property (p_irq_one) else $error("irq clear long");
    a_read_lat: assert property (p_read_lat) else $error("no read data");
    a_out_nak: assert property (p_out_nak) else $error("full not nak");
    a_setup_unstall: assert property (p_setup_unstall) else $error("stall kept");
    a_halt_cause: assert property (p_halt_cause) else $error("stall moved");
    a_unstall_init: assert property (p_unstall_init) else $error("no reinit");
    c_irq: cover property (irq_clear);
    c_unstall: cover property ($fell(ep_halted[0]));
    c_read: cover property (data_oe ##1 !data_oe);
endmodule // ep_status_checker

bind ep_status_commands ep_status_checker ep_status_checker_inst (
    .clk, .reset_n, .cs_n, .a0, .wr_n, .rd_n, .data_out, .data_oe,
    .ep_dbl_buf, .usb_event, .out_accept, .in_ready, .ep_halted,
    .in_toggle, .irq_clear
);

// ===== sim/cpu_bus_model.sv
// processor-side bus model issuing endpoint commands
`timescale 1ns/100ps
module cpu_bus_model (
    input  wire logic        clk,
    input  wire logic [15:0] data_out,
    output logic             cs_n,
    output logic             a0,
    output logic             wr_n,
    output logic             rd_n,
    output logic [15:0]      data_in
);
    initial begin
        cs_n = 1'b1;
        a0 = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        data_in = 16'h5AA5;
    end
    // code in the low lane, junk above
    task automatic cmd(input logic [7:0] code);
        @(posedge clk);
        cs_n    <= 1'b0;
        a0      <= 1'b1;
        wr_n    <= 1'b0;
        data_in <= {8'hC3, code};
        repeat (3) @(posedge clk);
        wr_n <= 1'b1;
        // wait out the sync stages so the action has landed
        repeat (5) @(posedge clk);
        cs_n    <= 1'b1;
        data_in <= ~data_in;
    endtask
    // result word in its own data phase
    task automatic rd(output logic [15:0] w);
        @(posedge clk);
        cs_n <= 1'b0;
        a0   <= 1'b0;
        rd_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1 w = data_out;
        @(posedge clk);
        rd_n <= 1'b1;
        repeat (3) @(posedge clk);
        cs_n <= 1'b1;
        a0   <= 1'b1;
    endtask
endmodule // cpu_bus_model

// ===== sim/tb_usb_endpoint_status_commands.sv
// self-checking bench for the endpoint command block
`timescale 1ns/100ps
module tb_usb_endpoint_status_commands;
    logic                      clk = 1'b0;
    logic                      reset_n = 1'b0;
    logic                      cs_n, a0, wr_n, rd_n, data_oe, irq_clear;
    logic [15:0]               data_in, data_out, out_accept, in_ready;
    logic [15:0]               ep_halted, in_toggle;
    logic [15:0]               ep_dbl_buf = 16'h0030;
    logic [3:0]                irq_clear_ep;
    logic [3:0]                last_irq = 4'hF;
    ep_status_pkg::usb_event_t usb_event = '0;
    int                        fails = 0;
    int                        comparisons = 0;
    always #25 clk = ~clk;
    always @(posedge clk) if (irq_clear === 1'b1) last_irq <= irq_clear_ep;
    ep_status_commands ep_status_commands_inst (.clk, .reset_n, .cs_n, .a0,
        .wr_n, .rd_n, .data_in, .data_out, .data_oe, .ep_dbl_buf, .usb_event,
        .out_accept, .in_ready, .ep_halted, .in_toggle, .irq_clear,
        .irq_clear_ep);
    cpu_bus_model cpu_bus_model_inst (.clk, .data_out, .cs_n, .a0, .wr_n,
        .rd_n, .data_in);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic ev(input ep_status_pkg::usb_event_kind_t k,
                      input logic [3:0] ep);
        @(posedge clk);
        usb_event <= {1'b1, k, ep};
        @(posedge clk);
        usb_event <= '0;
        @(posedge clk);
    endtask
    task automatic ask(input logic [7:0] code, output logic [15:0] w);
        cpu_bus_model_inst.cmd(code);
        cpu_bus_model_inst.rd(w);
    endtask
    task automatic t_reset;
        logic [15:0] w;
        check(out_accept, 16'hFFFF);
        for (int i = 0; i < 16; i++) begin
            ask(8'hD0 | 8'(i), w);
            check(w, {8'h00, ep_status_pkg::STATUS_RESET});
        end
        check({12'h000, last_irq}, 16'h000F);
    endtask
    task automatic t_stall;
        logic [15:0] w;
        ep_dbl_buf <= 16'hFFCF;
        for (int i = 0; i < 16; i++) begin
            cpu_bus_model_inst.cmd(8'h40 | 8'(i));
            check(ep_halted, 16'h0001 << i);
            ask(8'h50 | 8'(i), w);
            check(w, 16'h0080);
            check({12'h000, last_irq}, 16'(i));
            cpu_bus_model_inst.cmd(8'h80 | 8'(i));
            check(ep_halted, 16'h0000);
        end
        // second buffer takes the next packet; nak only when both full
        ev(ep_status_pkg::EV_OUT_DONE, 4'h6);
        check(out_accept, 16'hFFFF);
        ev(ep_status_pkg::EV_OUT_DONE, 4'h6);
        check(out_accept, 16'hFFBF);
        ask(8'hD6, w);
        check(w, 16'h0060);
        cpu_bus_model_inst.cmd(8'h76);
        ask(8'hD6, w);
        check(w, 16'h0042);
        cpu_bus_model_inst.cmd(8'h46);
        cpu_bus_model_inst.cmd(8'h86);
        check(in_toggle, 16'h0000);
        ep_dbl_buf <= 16'h0030;
    endtask
    task automatic t_out;
        logic [15:0] w;
        ev(ep_status_pkg::EV_OUT_DONE, 4'h3);
        check(out_accept, 16'hFFF7);
        ev(ep_status_pkg::EV_OUT_DONE, 4'h3);
        // contents trusted only after the packet completed
        ask(8'h53, w);
        check(w & 16'hFFEF, 16'h0020);
        cpu_bus_model_inst.cmd(8'h73);
        check(out_accept, 16'hFFFF);
        cpu_bus_model_inst.cmd(8'h60);
        check(in_ready, 16'h0000);
    endtask
    task automatic t_in;
        logic [15:0] w;
        cpu_bus_model_inst.cmd(8'h65);
        check(in_ready, 16'h0020);
        ask(8'hD5, w);
        check(w, 16'h0022);
        cpu_bus_model_inst.cmd(8'h65);
        ask(8'hD5, w);
        check(w, 16'h0060);
        ev(ep_status_pkg::EV_IN_SENT, 4'h5);
        ask(8'hD5, w);
        check(w, 16'h0050);
        cpu_bus_model_inst.cmd(8'h45);
        cpu_bus_model_inst.cmd(8'h85);
        // endpoint 3 still holds the toggle of its earlier out packet
        check(in_ready | in_toggle, 16'h0008);
        ev(ep_status_pkg::EV_DMA_WRAP, 4'h4);
        ask(8'hD4, w);
        check(w, 16'h0002);
    endtask
    task automatic t_setup;
        logic [15:0] w;
        cpu_bus_model_inst.cmd(8'h40);
        ev(ep_status_pkg::EV_SETUP_TOKEN, 4'h0);
        check(ep_halted, 16'h0000);
        ev(ep_status_pkg::EV_SETUP_DONE, 4'h0);
        ev(ep_status_pkg::EV_SETUP_TOKEN, 4'h0);
        // a read while setup data is still being written keeps the flag
        ask(8'h50, w);
        check(w & 16'h0008, 16'h0008);
        ev(ep_status_pkg::EV_SETUP_DONE, 4'h0);
        ask(8'hD0, w);
        check(w & 16'h000C, 16'h000C);
        // setup_clobbered_flag flag read before any acknowledge
        ask(8'h50, w);
        check(w & 16'h000C, 16'h000C);
        ask(8'hD0, w);
        check(w & 16'h0008, 16'h0000);
        cpu_bus_model_inst.cmd(8'h61);
        check(in_ready, 16'h0000);
        cpu_bus_model_inst.cmd(8'hF4);
        cpu_bus_model_inst.cmd(8'h61);
        check(in_ready, 16'h0000);
        ask(8'hD0, w);
        cpu_bus_model_inst.cmd(8'hF4);
        cpu_bus_model_inst.cmd(8'h61);
        check(in_ready, 16'h0002);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_stall;
        t_out;
        t_in;
        t_setup;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up;
    end
endmodule // tb_usb_endpoint_status_commands
